// File: inc/hrs_defines.svh
// hrs_defines.svh: offsets, field positions, reset values of the return stack
// assumes a 32-bit avalon-mm slave, one register per aligned word
`ifndef HRS_DEFINES_SVH
`define HRS_DEFINES_SVH

`define HRS_OFS_TOP_LOW 4'h0
`define HRS_OFS_TOP_HIGH 4'h4
`define HRS_OFS_PTR 4'h8
`define HRS_OFS_STATUS 4'hc

`define HRS_BIT_OVF 0
`define HRS_BIT_UNF 1

`define HRS_PTR_RST 5'h1f
`define HRS_PTR_FULL 5'h0f
`define HRS_PTR_EMPTY 5'h1f
`define HRS_PC_RST 15'h0000
`define HRS_RDATA_RST 32'h0000_0000
`define HRS_DEPTH 16

`endif

// File: inc/hrs_pkg.sv
// hrs_pkg: types shared by the return stack and its surroundings
// assumes nothing beyond the defines header
package hrs_pkg;

	// one step of the instruction sequencer toward the stack
	typedef struct packed {
		logic push;
		logic pop;
		logic [14:0] pc;
	} hrs_core_req_t;

	// avalon-mm request from the bus master
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} hrs_av_req_t;

	typedef enum logic {
		HRS_BUS_IDLE = 1'b0,
		HRS_BUS_ACK = 1'b1
	} hrs_bus_st_t;

endpackage : hrs_pkg

// File: src/hrs_return_stack.sv
// hrs_return_stack: sixteen-entry return-address stack with software access
// assumes push and pop come from logic on mclk, at most one of them per cycle
`timescale 1ns/1ps
`default_nettype none
`include "hrs_defines.svh"

// Contract
// R1 - sixteen entries of fifteen bits, apart from program and data memory
// R2 - call, call via w register and interrupt vectoring push the program counter
// R3 - return, return with literal and return from interrupt pop into the program counter
// R4 - push and pop leave the program counter high latch untouched
// R5 - with error reset disabled the stack wraps, seventeenth push overwrites the first
// R6 - overflow and underflow set their flags whether or not error reset is on
// R7 - top entry readable and writable as a low and high register pair
// R8 - software writes the pointer first; top entry accesses then hit that entry
// R9 - pointer is five bits so overflow and underflow are detectable
// R10 - calls and interrupts increment the pointer, returns decrement it
// R11 - push increments then writes; pop reads then decrements
// R12 - software takes care changing the pointer while interrupts are enabled
// R13 - with error reset enabled, overflow or underflow also requests a device reset
module hrs_return_stack (
	input wire logic mclk,
	input wire logic srst,
	input wire hrs_pkg::hrs_core_req_t core_req,
	output logic [14:0] pop_pc,
	input wire logic stack_error_reset_enable,
	output logic stack_reset_req,
	input wire hrs_pkg::hrs_av_req_t av_req,
	output logic [31:0] av_readdata,
	output logic av_waitrequest
);
	import hrs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [14:0] stack_ff [`HRS_DEPTH]; // R1
	logic [14:0] nxt_stack [`HRS_DEPTH];
	logic [4:0] ptr_ff; // R9
	logic [4:0] nxt_ptr;
	logic ovf_ff;
	logic nxt_ovf;
	logic unf_ff;
	logic nxt_unf;
	logic [14:0] pop_pc_ff;
	logic [14:0] nxt_pop_pc;
	logic rst_req_ff;
	logic nxt_rst_req;
	hrs_bus_st_t bus_ff;
	hrs_bus_st_t nxt_bus;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	logic bus_req;
	logic bus_wr;
	logic do_push;
	logic do_pop;
	logic over_ev;
	logic under_ev;
	logic [4:0] ptr_up;
	logic [4:0] ptr_dn;
	logic [3:0] sel;
	logic [14:0] top_val;

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait state, then the answer

	assign bus_req = av_req.read | av_req.write;
	assign av_waitrequest = bus_req & (bus_ff == HRS_BUS_IDLE);
	assign bus_wr = av_req.write & (bus_ff == HRS_BUS_ACK);
	assign av_readdata = rdata_ff;

	always_comb begin
		nxt_bus = HRS_BUS_IDLE;
		unique case (bus_ff)
			HRS_BUS_IDLE: begin
				if (bus_req) begin
					nxt_bus = HRS_BUS_ACK;
				end
			end
			HRS_BUS_ACK: begin
				nxt_bus = HRS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			bus_ff <= HRS_BUS_IDLE;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stack pointer and entries

	assign do_push = core_req.push;
	assign do_pop = core_req.pop & ~core_req.push;
	assign ptr_up = ptr_ff + 5'h01;
	assign ptr_dn = ptr_ff - 5'h01;
	assign sel = ptr_ff[3:0];
	assign top_val = stack_ff[sel];
	assign over_ev = do_push & (ptr_ff == `HRS_PTR_FULL);
	assign under_ev = do_pop & (ptr_ff == `HRS_PTR_EMPTY);

	always_comb begin
		nxt_stack = stack_ff;
		nxt_ptr = ptr_ff;
		nxt_pop_pc = pop_pc_ff;
		if (do_push) begin
			// increment first, then store; index wraps past the last entry
			nxt_ptr = ptr_up; // R10 R11
			nxt_stack[ptr_up[3:0]] = core_req.pc; // R2 R5 R11
		end else if (do_pop) begin
			// read the current entry, then step back
			nxt_pop_pc = top_val; // R3 R11
			nxt_ptr = ptr_dn; // R10
		end else if (bus_wr) begin
			// software goes through the entry the pointer selects, or sets the pointer itself
			unique case (av_req.address)
				`HRS_OFS_TOP_LOW: begin
					nxt_stack[sel][7:0] = av_req.writedata[7:0]; // R7 R8
				end
				`HRS_OFS_TOP_HIGH: begin
					nxt_stack[sel][14:8] = av_req.writedata[6:0]; // R7 R8
				end
				`HRS_OFS_PTR: begin
					nxt_ptr = av_req.writedata[4:0]; // R8 R12
				end
				default: begin
					nxt_ptr = ptr_ff;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		stack_ff <= nxt_stack;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ptr_ff <= `HRS_PTR_RST;
			pop_pc_ff <= `HRS_PC_RST;
		end else begin
			ptr_ff <= nxt_ptr;
			pop_pc_ff <= nxt_pop_pc;
		end
	end

	// only the fifteen-bit counter value leaves; the high latch is not driven here
	assign pop_pc = pop_pc_ff; // R4

	////////////////////////////////////////////////////////////////////////////////
	// error flags and reset request

	always_comb begin
		nxt_ovf = ovf_ff;
		nxt_unf = unf_ff;
		// writing a one clears a flag; a fresh event wins over the clear
		if (bus_wr && av_req.address == `HRS_OFS_STATUS) begin
			if (av_req.writedata[`HRS_BIT_OVF]) begin
				nxt_ovf = 1'b0;
			end
			if (av_req.writedata[`HRS_BIT_UNF]) begin
				nxt_unf = 1'b0;
			end
		end
		if (over_ev) begin
			nxt_ovf = 1'b1; // R6
		end
		if (under_ev) begin
			nxt_unf = 1'b1; // R6
		end
		nxt_rst_req = stack_error_reset_enable & (over_ev | under_ev); // R13
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ovf_ff <= 1'b0;
			unf_ff <= 1'b0;
			rst_req_ff <= 1'b0;
		end else begin
			ovf_ff <= nxt_ovf;
			unf_ff <= nxt_unf;
			rst_req_ff <= nxt_rst_req;
		end
	end

	assign stack_reset_req = rst_req_ff;

	////////////////////////////////////////////////////////////////////////////////
	// read data, captured during the wait state

	always_comb begin
		nxt_rdata = rdata_ff;
		if (av_req.read && bus_ff == HRS_BUS_IDLE) begin
			nxt_rdata = `HRS_RDATA_RST;
			unique case (av_req.address)
				`HRS_OFS_TOP_LOW: begin
					nxt_rdata[7:0] = top_val[7:0]; // R7 R8
				end
				`HRS_OFS_TOP_HIGH: begin
					nxt_rdata[6:0] = top_val[14:8]; // R7 R8
				end
				`HRS_OFS_PTR: begin
					nxt_rdata[4:0] = ptr_ff; // R9
				end
				`HRS_OFS_STATUS: begin
					nxt_rdata[`HRS_BIT_OVF] = ovf_ff;
					nxt_rdata[`HRS_BIT_UNF] = unf_ff;
				end
				default: begin
					nxt_rdata = `HRS_RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_ff <= `HRS_RDATA_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	push_ptr_a: assert property ( // R10
		do_push |=> ptr_ff == $past(ptr_up)
	) else $error("pointer did not advance on push");

	pop_ptr_a: assert property ( // R10
		do_pop |=> ptr_ff == $past(ptr_dn)
	) else $error("pointer did not step back on pop");

	push_store_a: assert property ( // R11
		do_push |=> stack_ff[ptr_ff[3:0]] == $past(core_req.pc)
	) else $error("pushed value not at new top");

	pop_data_a: assert property ( // R3
		do_pop |=> pop_pc == $past(top_val)
	) else $error("popped value not the old top");

	ovf_flag_a: assert property ( // R6
		over_ev |=> ovf_ff
	) else $error("overflow flag not set");

	unf_flag_a: assert property ( // R6
		under_ev |=> unf_ff
	) else $error("underflow flag not set");

	wrap_slot_a: assert property ( // R5
		over_ev |=> ptr_ff == 5'h10 && stack_ff[4'h0] == $past(core_req.pc)
	) else $error("seventeenth push did not overwrite first entry");

	err_reset_a: assert property ( // R13
		(over_ev || under_ev) && stack_error_reset_enable |=> stack_reset_req
	) else $error("stack error did not request reset");

	no_reset_a: assert property ( // R13
		!stack_error_reset_enable ##1 1'b1 |-> !stack_reset_req
	) else $error("reset requested while error reset disabled");

	bus_wait_a: assert property ( // R8
		av_waitrequest |=> !av_waitrequest ##1 !bus_req || av_waitrequest
	) else $error("bus answer not after one wait state");

	// pointer moves only on push, pop or a software write
	ptr_hold_a: assert property ( // R10
		!do_push && !do_pop && !bus_wr |=> $stable(ptr_ff)
	) else $error("pointer moved without a request");

	// popped value stands until the next pop
	pop_hold_a: assert property ( // R3
		!do_pop |=> $stable(pop_pc)
	) else $error("popped value changed without a pop");

	// a pointer write with no core request lands as written
	ptr_write_a: assert property ( // R8
		bus_wr && av_req.address == `HRS_OFS_PTR && !do_push && !do_pop
		|=> ptr_ff == $past(av_req.writedata[4:0])
	) else $error("pointer write did not land");

	// a low-half write reaches the entry that the pointer selects
	top_write_a: assert property ( // R7
		bus_wr && av_req.address == `HRS_OFS_TOP_LOW && !do_push && !do_pop
		|=> stack_ff[sel][7:0] == $past(av_req.writedata[7:0])
	) else $error("top entry write did not land");

	// overflow flag stays until software clears it
	ovf_hold_a: assert property ( // R6
		ovf_ff && !(bus_wr && av_req.address == `HRS_OFS_STATUS) |=> ovf_ff
	) else $error("overflow flag lost without a clear");

	// underflow flag stays until software clears it
	unf_hold_a: assert property ( // R6
		unf_ff && !(bus_wr && av_req.address == `HRS_OFS_STATUS) |=> unf_ff
	) else $error("underflow flag lost without a clear");

	// no reset request without a stack error the cycle before
	req_cause_a: assert property ( // R13
		!(over_ev || under_ev) |=> !stack_reset_req
	) else $error("reset requested without a stack error");

endmodule : hrs_return_stack
`default_nettype wire

// File: test/hrs_seq_model.sv
// hrs_seq_model: instruction sequencer issuing pushes and pops to the stack
// assumes one request per cycle, driven right after the rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module hrs_seq_model (
	input wire logic mclk,
	output var hrs_pkg::hrs_core_req_t core_req
);
	import hrs_pkg::*;
	initial core_req = '0;
	// back-to-back pushes, one each cycle; pc inverted while idle
	task automatic push_burst(input int n, input logic [14:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			core_req <= '{push: 1'b1, pop: 1'b0, pc: base + 15'(i)};
		end
		@(posedge mclk);
		core_req <= '{push: 1'b0, pop: 1'b0, pc: ~(base + 15'(n - 1))};
	endtask : push_burst
	task automatic pop_one();
		@(posedge mclk);
		core_req.pop <= 1'b1;
		@(posedge mclk);
		core_req.pop <= 1'b0;
	endtask : pop_one
endmodule : hrs_seq_model
`default_nettype wire

// File: test/hrs_return_stack_tb.sv
// hrs_return_stack_tb: register and core-port tests of the return stack
// assumes the sequencer model and one wait state per bus access
`timescale 1ns/1ps
`default_nettype none
`include "hrs_defines.svh"
module hrs_return_stack_tb;
	import hrs_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic err_en = 1'b0;
	hrs_core_req_t core_req;
	hrs_av_req_t av_req = '0;
	logic [14:0] pop_pc;
	logic stack_reset_req;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	int num_errors = 0;
	int cmp_count = 0;
	hrs_seq_model i_hrs_seq_model (.mclk(mclk), .core_req(core_req));
	hrs_return_stack i_hrs_return_stack (.mclk(mclk), .srst(srst), .core_req(core_req),
		.pop_pc(pop_pc), .stack_error_reset_enable(err_en),
		.stack_reset_req(stack_reset_req), .av_req(av_req), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest));
	initial begin
		forever #50 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// request held until waitrequest is seen low at a falling edge, released at the next rising edge
	task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
		do begin
			@(negedge mclk);
			n++;
		end while (av_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			num_errors++;
			give_verdict();
		end
		@(posedge mclk);
		q = av_readdata;
		av_req <= '0;
	endtask : av_xfer
	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_xfer(1'b1, a, d, q);
	endtask : av_wr
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		av_xfer(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask : rd_chk
	task automatic top_chk(input logic [14:0] p);
		rd_chk(`HRS_OFS_TOP_LOW, {24'h0, p[7:0]}, "top low");
		rd_chk(`HRS_OFS_TOP_HIGH, {25'h0, p[14:8]}, "top high");
	endtask : top_chk
	task automatic pop_chk(input logic [14:0] p);
		i_hrs_seq_model.pop_one();
		@(negedge mclk);
		chk("pop_pc", {17'h0, p}, {17'h0, pop_pc});
	endtask : pop_chk
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		rd_chk(`HRS_OFS_PTR, 32'h1f, "ptr reset");
		rd_chk(`HRS_OFS_STATUS, 32'h0, "status reset");
		i_hrs_seq_model.push_burst(2, 15'h7a51);
		rd_chk(`HRS_OFS_PTR, 32'h1, "ptr push");
		top_chk(15'h7a52);
		av_wr(`HRS_OFS_PTR, 32'h0);
		top_chk(15'h7a51);
		av_wr(`HRS_OFS_PTR, 32'h1);
		pop_chk(15'h7a52);
		pop_chk(15'h7a51);
		rd_chk(`HRS_OFS_PTR, 32'h1f, "ptr pop");
		i_hrs_seq_model.pop_one();
		rd_chk(`HRS_OFS_STATUS, 32'h2, "underflow");
		av_wr(`HRS_OFS_STATUS, 32'h3);
		rd_chk(`HRS_OFS_STATUS, 32'h0, "status clear");
		av_wr(`HRS_OFS_PTR, 32'h1f);
		i_hrs_seq_model.push_burst(17, 15'h0100);
		rd_chk(`HRS_OFS_PTR, 32'h10, "ptr wrap");
		rd_chk(`HRS_OFS_STATUS, 32'h1, "overflow");
		av_wr(`HRS_OFS_PTR, 32'h0);
		top_chk(15'h0110);
		av_wr(`HRS_OFS_PTR, 32'h1);
		top_chk(15'h0101);
		av_wr(`HRS_OFS_PTR, 32'h5);
		av_wr(`HRS_OFS_TOP_LOW, 32'hffff_ffcd);
		av_wr(`HRS_OFS_TOP_HIGH, 32'hffff_ff2b);
		top_chk(15'h2bcd);
		pop_chk(15'h2bcd);
		rd_chk(4'h1, 32'h0, "unmapped");
		@(posedge mclk);
		err_en <= 1'b1;
		av_wr(`HRS_OFS_STATUS, 32'h3);
		av_wr(`HRS_OFS_PTR, 32'hf);
		i_hrs_seq_model.push_burst(1, 15'h0042);
		@(negedge mclk);
		chk("reset_req", 32'h1, {31'h0, stack_reset_req});
		@(negedge mclk);
		chk("reset_req end", 32'h0, {31'h0, stack_reset_req});
		rd_chk(`HRS_OFS_STATUS, 32'h1, "flag kept");
		give_verdict();
	end
endmodule : hrs_return_stack_tb
`default_nettype wire
